//--- bench/pas_fault_src.sv
// pas_fault_src: fault pin and comparator levels at the far side
`timescale 1ns/10ps
module pas_fault_src (
   // request bit 0 fault pin, bit 1 comparator 1, bit 2 comparator 2, and the lines
   input wire logic [2:0] want,
   output logic faultInputN,
   output logic cmp1Out,
   output logic cmp2Out
);
   assign faultInputN = !want[0];
   assign cmp1Out = want[1];
   assign cmp2Out = want[2];
endmodule

//--- bench/pas_shutdown_pwm_test.sv
// pas_shutdown_pwm_test: self-checking bench of the auto-shutdown block
`timescale 1ns/10ps
module pas_shutdown_pwm_test;
   import pas_pkg::*;
   logic clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic awr, wrd, bv, arr, rv, fN, c1, c2, hi, lo, osc;
   logic slp = 1'b0, cme = 1'b0, cfe = 1'b0;
   logic [7:0] ad = 8'h00, wd = 8'h00;
   logic [31:0] q, rd;
   logic [1:0] r, br, rr;
   logic [2:0] want = 3'h0;
   logic [3:0] bo, oe;
   int miscompares = 0, total_checks = 0;
   initial forever #25 clk = !clk;
   pas_fault_src pas_fault_src_i (.want(want), .faultInputN(fN), .cmp1Out(c1), .cmp2Out(c2));
   pas_shutdown_pwm pas_shutdown_pwm_i (.clk(clk), .srst(srst), .s_axi_awaddr(ad), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata({24'h0, wd}), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ad), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .faultInputN(fN), .cmp1Out(c1), .cmp2Out(c2), .sleepMode(slp), .clkMonEnable(cme),
      .clkFailEvent(cfe), .internalOscRun(osc), .bridgeOut(bo), .bridgeOe(oe));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic wt, input logic [7:0] a, input logic [7:0] d);
      logic aw, w, ar, b;
      @(posedge clk);
      ad <= a;
      wd <= d;
      {awv, wv, brdy, arv, rrdy} <= {wt, wt, wt, !wt, !wt};
      do begin
         // sample settled handshakes mid-cycle, act on them at the next rising edge
         @(negedge clk);
         {aw, w, ar, b, q, r} = {awr, wrd, arr, wt ? bv : rv, rd, wt ? br : rr};
         @(posedge clk);
         {awv, wv, arv} <= {awv & !aw, wv & !w, arv & !ar};
      end while (!b);
      {brdy, rrdy} <= 2'h0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(n, {24'h0, e}, q);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_start();
      chk("oe", 4'h0, oe);
      rchk("period", OFF_PERIOD, 8'hFF);
      bus(1'b0, 8'h28, 8'h00);
      chk("resp", RESP_SLVERR, r);
      bus(1'b1, 8'h28, 8'h00);
      chk("bresp", RESP_SLVERR, r);
      bus(1'b1, OFF_PERIOD, 8'h03);
      bus(1'b1, OFF_SHUT, 8'h94);
      bus(1'b1, OFF_RESTART, 8'h05);
      bus(1'b1, OFF_FLAGS1, 8'h00);
      bus(1'b1, OFF_TIMER, 8'h04);
      rchk("flag", OFF_FLAGS1, 8'h00);
      repeat (30) @(posedge clk);
      rchk("flag", OFF_FLAGS1, 8'h02);
      bus(1'b1, OFF_DIR, 8'h00);
   endtask
   task automatic t_shut();
      bus(1'b1, OFF_SHUT, 8'h14);
      want <= 3'h2;
      repeat (4) @(negedge clk);
      chk("safe", 4'h5, bo);
      bus(1'b1, OFF_SHUT, 8'h14);
      rchk("stat", OFF_SHUT, 8'h94);
      want <= 3'h0;
      repeat (8) @(posedge clk);
      rchk("held", OFF_SHUT, 8'h94);
      bus(1'b1, OFF_SHUT, 8'h8A);
      chk("tri", 4'h0, oe);
      bus(1'b1, OFF_SHUT, 8'h14);
      rchk("clear", OFF_SHUT, 8'h14);
      // longer than one period, so the held shutdown is released
      repeat (20) @(posedge clk);
      chk("run", 4'h0, bo);
   endtask
   task automatic t_src();
      // without auto restart a stale status would leave the next idle case forced
      bus(1'b1, OFF_RESTART, 8'h80);
      for (int s = 0; s < 8; s++) begin
         for (int w = 1; w < 8; w = w * 2) begin
            bus(1'b1, OFF_SHUT, {1'b0, 3'(s), 4'h5});
            want <= 3'(w);
            repeat (4) @(negedge clk);
            chk("src", (3'({s[1], s[0], s[2]}) & 3'(w)) != 3'h0 ? 4'hF : 4'h0, bo);
            @(posedge clk);
            want <= 3'h0;
            repeat (40) @(posedge clk);
         end
      end
      bus(1'b1, OFF_DIR, 8'h0F);
      bus(1'b1, OFF_MODE, 8'h32);
      bus(1'b1, OFF_DIR, 8'h00);
      {hi, lo} = 2'h0;
      repeat (40) begin
         @(negedge clk);
         {hi, lo} = {hi | bo[1], lo | (bo === 4'h5)};
      end
      chk("lsb", 1'b1, hi);
      chk("pol", 1'b1, lo);
   endtask
   task automatic t_power();
      logic [31:0] q0;
      logic [3:0] b0;
      @(posedge clk);
      {cme, cfe} <= 2'h3;
      @(posedge clk);
      cfe <= 1'b0;
      @(negedge clk);
      chk("osc", 1'b1, osc);
      rchk("fail", OFF_FLAGS2, 8'h80);
      slp <= 1'b1;
      bus(1'b0, OFF_STATUS, 8'h00);
      {q0, b0} = {q, bo};
      repeat (20) @(posedge clk);
      bus(1'b0, OFF_STATUS, 8'h00);
      chk("frozen", q0, q);
      chk("held", b0, bo);
      slp <= 1'b0;
      // six ticks of the prescaler move the count by one or two
      repeat (5) @(posedge clk);
      bus(1'b0, OFF_STATUS, 8'h00);
      chk("wake", 1'b1, q != q0);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      chk("rst", 5'h00, {osc, oe});
      rchk("dir", OFF_DIR, 8'h0F);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_start();
      t_shut();
      t_src();
      t_power();
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule

//--- core/pas_period_timer.sv
// pas_period_timer: prescaled period timer with period start pulse
`timescale 1ns/10ps
module pas_period_timer (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link to the shutdown core
   pas_tmr_if.timer tl
);
   import pas_pkg::*;

   typedef struct packed {
      logic [PRESC_W-1:0] presc;
      logic [TMR_W-1:0] count;
      logic start;
   } pas_tmr_state_t;

   pas_tmr_state_t st_r, st_nxt;
   logic [PRESC_W-1:0] lastPresc;

   assign lastPresc = (tl.prescale == PS_SEL_1) ? PRESC_LAST1 :
                      (tl.prescale == PS_SEL_4) ? PRESC_LAST4 : PRESC_LAST16;
   // the two duty lsbs compare against the top of the prescaler
   assign tl.fine = (tl.prescale == PS_SEL_1) ? st_r.presc[1:0] :
                    (tl.prescale == PS_SEL_4) ? st_r.presc[3:2] : st_r.presc[5:4];
   assign tl.count = st_r.count;
   assign tl.periodStart = st_r.start;

   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      // idle modes keep clocking; only sleep or a clear run bit stops the count
      if (tl.run && !tl.freeze) begin
         if (st_r.presc >= lastPresc) begin
            st_nxt.presc = '0;
            if (st_r.count == tl.periodLimit) begin
               st_nxt.count = '0;
               st_nxt.start = 1'b1;
            end else begin
               st_nxt.count = st_r.count + 1'b1;
            end
         end else begin
            st_nxt.presc = st_r.presc + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   a_freeze_count: assert property (@(posedge clk) disable iff (srst)
      tl.freeze |=> $stable(st_r.count) && $stable(st_r.presc))
      else $error("timer moved during sleep");
   a_wrap_start: assert property (@(posedge clk) disable iff (srst)
      (tl.run && !tl.freeze && st_r.presc >= lastPresc && st_r.count == tl.periodLimit)
      |=> tl.periodStart && st_r.count == '0)
      else $error("period start missing at limit");
endmodule

//--- core/pas_pkg.sv
// pas_pkg: constants and types of the pwm auto-shutdown and restart block
// Behaviour
// - restart enable bit gates automatic restart
// - auto restart: status follows cause, clears after
// - no auto restart: status holds until software clears
// - outputs resume only at next period start
// - status writes ignored while shutdown cause active
// - comparator shutdown is a level, blocks clearing
// - writing one to status forces shutdown
// - reset: pins inputs, registers to reset values
// - polarity bits choose per pair active level
// - period flag set when second period begins
// - duty is high byte plus two mode bits
// - sleep freezes timer and module state
// - idle modes keep the timer running
// - clock failure sets fail flag, internal oscillator run
// - three-bit source select decode
// - pair safe state: low, high, tri-state
// - shutdown forces pins without waiting for clock
// - status set at period start holds whole period
package pas_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int TMR_W = 8;
   localparam int DUTY_W = 10;
   localparam int PRESC_W = 6;
   localparam int PIN_N = 4;
   localparam int AUX_N = 4;
   localparam int SRC_N = 3;
   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [ADDR_W-1:0] OFF_RESTART = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_SHUT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MODE = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_DUTY = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_TIMER = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_FLAGS1 = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_FLAGS2 = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_DIR = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
   // enables 1, priority 1, enables 2, priority 2 at 30, 34, 38, 3C
   localparam logic [ADDR_W-1:0] AUX_BASE = 8'h30;
   localparam logic [ADDR_W-1:0] AUX_MASK = 8'hF3;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int B_RESTART_EN = 7;
   localparam int B_SHUT_STAT = 7;
   localparam int SRC_HI = 6;
   localparam int SRC_LO = 4;
   localparam int AC_HI = 3;
   localparam int AC_LO = 2;
   localparam int BD_HI = 1;
   localparam int BD_LO = 0;
   localparam int DLSB_HI = 5;
   localparam int DLSB_LO = 4;
   localparam int B_POL_AC = 1;
   localparam int B_POL_BD = 0;
   localparam int PS_HI = 1;
   localparam int PS_LO = 0;
   localparam int B_TMR_RUN = 2;
   localparam int B_TMR_FLAG = 1;
   localparam int B_CLK_FAIL = 7;
   localparam logic [REG_W-1:0] RST_PERIOD = 8'hFF;
   localparam logic [PIN_N-1:0] RST_DIR = 4'hF;
   // ****************************************
   // timing: clk is the oscillator, one instruction cycle is four clocks
   // ****************************************
   localparam int TCY_CLKS = 4;
   localparam int PS_RATIO_4 = 4;
   localparam int PS_RATIO_16 = 16;
   localparam logic [PRESC_W-1:0] PRESC_LAST1 = PRESC_W'(TCY_CLKS - 1);
   localparam logic [PRESC_W-1:0] PRESC_LAST4 = PRESC_W'(TCY_CLKS * PS_RATIO_4 - 1);
   localparam logic [PRESC_W-1:0] PRESC_LAST16 = PRESC_W'(TCY_CLKS * PS_RATIO_16 - 1);
   localparam logic [1:0] PS_SEL_1 = 2'h0;
   localparam logic [1:0] PS_SEL_4 = 2'h1;
   // ****************************************
   // encodings
   // ****************************************
   localparam logic [2:0] SRC_CMP1 = 3'h1;
   localparam logic [2:0] SRC_CMP2 = 3'h2;
   localparam logic [2:0] SRC_CMP_ANY = 3'h3;
   localparam logic [2:0] SRC_FLT = 3'h4;
   localparam logic [2:0] SRC_FLT_C1 = 3'h5;
   localparam logic [2:0] SRC_FLT_C2 = 3'h6;
   localparam logic [2:0] SRC_FLT_ALL = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRESP = 3'b010,
      BUS_RRESP = 3'b100
   } pas_bus_t;
endpackage

//--- core/pas_shutdown_pwm.sv
// pas_shutdown_pwm: auto-shutdown, restart and output stage of a pwm bridge
`timescale 1ns/10ps
module pas_shutdown_pwm (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // axi4-lite write channels
   input wire logic [pas_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [pas_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [pas_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [pas_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // shutdown sources
   input wire logic faultInputN,
   input wire logic cmp1Out,
   input wire logic cmp2Out,
   // power management
   input wire logic sleepMode,
   input wire logic clkMonEnable,
   input wire logic clkFailEvent,
   output logic internalOscRun,
   // bridge pins, bit 0 a, 1 b, 2 c, 3 d
   output logic [pas_pkg::PIN_N-1:0] bridgeOut,
   output logic [pas_pkg::PIN_N-1:0] bridgeOe
);
   import pas_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      pas_bus_t bus;
      logic awHave;
      logic [ADDR_W-1:0] awAddr;
      logic wHave;
      logic [REG_W-1:0] wData;
      logic wLane;
      logic [DATA_W-1:0] rData;
      logic [1:0] resp;
      logic [REG_W-1:0] restartCtrl;
      logic [REG_W-1:0] shutCtrl;
      logic [REG_W-1:0] modeCtrl;
      logic [REG_W-1:0] dutyHigh;
      logic [REG_W-1:0] periodLimit;
      logic [REG_W-1:0] timerCtrl;
      logic [REG_W-1:0] irqFlags1;
      logic [REG_W-1:0] irqFlags2;
      logic [AUX_N-1:0][REG_W-1:0] irqAux;
      logic [PIN_N-1:0] pinDir;
      logic [DUTY_W-1:0] dutyLatched;
      logic heldShut;
      logic pwmOn;
      logic oscRun;
      logic [SRC_N-1:0] sync1;
      logic [SRC_N-1:0] sync2;
   } pas_state_t;

   pas_state_t st_r, st_nxt;
   pas_tmr_if tmrLink();

   logic [SRC_N-1:0] srcLevel;
   logic [2:0] srcSel;
   logic causeRaw;
   logic causeSync;
   logic shutNow;
   logic wrNow;
   logic shutWr;
   logic restartEn;
   logic statNow;

   // ****************************************
   // helpers
   // ****************************************
   // lv holds {cmp2, cmp1, fault}, all active high
   function automatic logic srcHit(input logic [2:0] sel, input logic [SRC_N-1:0] lv);
      case (sel)
         SRC_CMP1: srcHit = lv[1];
         SRC_CMP2: srcHit = lv[2];
         SRC_CMP_ANY: srcHit = lv[1] | lv[2];
         SRC_FLT: srcHit = lv[0];
         SRC_FLT_C1: srcHit = lv[0] | lv[1];
         SRC_FLT_C2: srcHit = lv[0] | lv[2];
         SRC_FLT_ALL: srcHit = |lv;
         default: srcHit = 1'b0;
      endcase
   endfunction

   function automatic logic isAux(input logic [ADDR_W-1:0] a);
      isAux = (a & AUX_MASK) == AUX_BASE;
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_RESTART, OFF_SHUT, OFF_MODE, OFF_DUTY, OFF_PERIOD, OFF_TIMER,
         OFF_FLAGS1, OFF_FLAGS2, OFF_DIR, OFF_STATUS: isMapped = 1'b1;
         default: isMapped = isAux(a);
      endcase
   endfunction

   // ****************************************
   // shutdown cause and output forcing
   // ****************************************
   assign srcSel = st_r.shutCtrl[SRC_HI:SRC_LO];
   assign srcLevel = {cmp2Out, cmp1Out, ~faultInputN};
   assign causeRaw = srcHit(srcSel, srcLevel);
   // clearing looks at both the raw cause and the second stage so a glitch cannot half-clear
   assign causeSync = srcHit(srcSel, st_r.sync2);
   assign statNow = st_r.shutCtrl[B_SHUT_STAT];
   assign restartEn = st_r.restartCtrl[B_RESTART_EN];
   // the raw cause forces pins at once, without a clock edge
   assign shutNow = causeRaw | statNow | st_r.heldShut;
   assign internalOscRun = st_r.oscRun;

   generate
      for (genvar i = 0; i < PIN_N; i++) begin : g_pin
         logic [1:0] safeState;
         logic polLow;
         // even pins form the a/c pair, odd pins the b/d pair
         if (i % 2 == 0) begin : g_ac
            assign safeState = st_r.shutCtrl[AC_HI:AC_LO];
            assign polLow = st_r.modeCtrl[B_POL_AC];
         end else begin : g_bd
            assign safeState = st_r.shutCtrl[BD_HI:BD_LO];
            assign polLow = st_r.modeCtrl[B_POL_BD];
         end
         assign bridgeOut[i] = shutNow ? safeState[0] : (st_r.pwmOn ^ polLow);
         // a pin drives only once software has made it an output
         assign bridgeOe[i] = ~st_r.pinDir[i] & ~(shutNow & safeState[1]);
      end
   endgenerate

   // ****************************************
   // period timer
   // ****************************************
   assign tmrLink.periodLimit = st_r.periodLimit;
   assign tmrLink.prescale = st_r.timerCtrl[PS_HI:PS_LO];
   assign tmrLink.run = st_r.timerCtrl[B_TMR_RUN];
   assign tmrLink.freeze = sleepMode;

   pas_period_timer u_timer (
      .clk(clk),
      .srst(srst),
      .tl(tmrLink)
   );

   // ****************************************
   // bus handshakes
   // ****************************************
   assign s_axi_awready = (st_r.bus == BUS_IDLE) && !st_r.awHave;
   assign s_axi_wready = (st_r.bus == BUS_IDLE) && !st_r.wHave;
   // a read waits while half of a write is held
   assign s_axi_arready = (st_r.bus == BUS_IDLE) && !st_r.awHave && !st_r.wHave;
   assign s_axi_bvalid = st_r.bus == BUS_WRESP;
   assign s_axi_bresp = st_r.resp;
   assign s_axi_rvalid = st_r.bus == BUS_RRESP;
   assign s_axi_rresp = st_r.resp;
   assign s_axi_rdata = st_r.rData;
   assign wrNow = (st_r.bus == BUS_IDLE) && st_r.awHave && st_r.wHave;
   assign shutWr = wrNow && st_r.wLane && (st_r.awAddr == OFF_SHUT);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      case (st_r.bus)
         BUS_IDLE: begin
            if (s_axi_awvalid && s_axi_awready) begin
               st_nxt.awHave = 1'b1;
               st_nxt.awAddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               st_nxt.wHave = 1'b1;
               st_nxt.wData = s_axi_wdata[REG_W-1:0];
               st_nxt.wLane = s_axi_wstrb[0];
            end
            if (wrNow) begin
               st_nxt.awHave = 1'b0;
               st_nxt.wHave = 1'b0;
               st_nxt.bus = BUS_WRESP;
               st_nxt.resp = isMapped(st_r.awAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_arvalid && s_axi_arready) begin
               st_nxt.bus = BUS_RRESP;
               st_nxt.resp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
               st_nxt.rData = '0;
               case (s_axi_araddr)
                  OFF_RESTART: st_nxt.rData[REG_W-1:0] = st_r.restartCtrl;
                  OFF_SHUT: st_nxt.rData[REG_W-1:0] = st_r.shutCtrl;
                  OFF_MODE: st_nxt.rData[REG_W-1:0] = st_r.modeCtrl;
                  OFF_DUTY: st_nxt.rData[REG_W-1:0] = st_r.dutyHigh;
                  OFF_PERIOD: st_nxt.rData[REG_W-1:0] = st_r.periodLimit;
                  OFF_TIMER: st_nxt.rData[REG_W-1:0] = st_r.timerCtrl;
                  OFF_FLAGS1: st_nxt.rData[REG_W-1:0] = st_r.irqFlags1;
                  OFF_FLAGS2: st_nxt.rData[REG_W-1:0] = st_r.irqFlags2;
                  OFF_DIR: st_nxt.rData[PIN_N-1:0] = st_r.pinDir;
                  // live view: count, forced, synced cause, oscillator fallback
                  OFF_STATUS: st_nxt.rData[TMR_W+2:0] = {st_r.oscRun, causeSync, shutNow, tmrLink.count};
                  default: begin
                     if (isAux(s_axi_araddr)) begin
                        st_nxt.rData[REG_W-1:0] = st_r.irqAux[s_axi_araddr[3:2]];
                     end
                  end
               endcase
            end
         end
         BUS_WRESP: begin
            if (s_axi_bready) begin
               st_nxt.bus = BUS_IDLE;
            end
         end
         BUS_RRESP: begin
            if (s_axi_rready) begin
               st_nxt.bus = BUS_IDLE;
            end
         end
         default: begin
            st_nxt.bus = BUS_IDLE;
         end
      endcase

      if (wrNow && st_r.wLane) begin
         case (st_r.awAddr)
            OFF_RESTART: st_nxt.restartCtrl = st_r.wData;
            // the status bit is settled below, never by a plain store
            OFF_SHUT: st_nxt.shutCtrl[SRC_HI:0] = st_r.wData[SRC_HI:0];
            OFF_MODE: st_nxt.modeCtrl = st_r.wData;
            OFF_DUTY: st_nxt.dutyHigh = st_r.wData;
            OFF_PERIOD: st_nxt.periodLimit = st_r.wData;
            OFF_TIMER: st_nxt.timerCtrl = st_r.wData;
            OFF_FLAGS1: st_nxt.irqFlags1 = st_r.wData;
            OFF_FLAGS2: st_nxt.irqFlags2 = st_r.wData;
            OFF_DIR: st_nxt.pinDir = st_r.wData[PIN_N-1:0];
            default: begin
               if (isAux(st_r.awAddr)) begin
                  st_nxt.irqAux[st_r.awAddr[3:2]] = st_r.wData;
               end
            end
         endcase
      end

      // sleep stops every clock: nothing below may move
      if (!sleepMode) begin
         st_nxt.sync1 = srcLevel;
         st_nxt.sync2 = st_r.sync1;
         if (restartEn && !causeRaw && !causeSync) begin
            st_nxt.shutCtrl[B_SHUT_STAT] = 1'b0;
         end
         if (shutWr) begin
            if (st_r.wData[B_SHUT_STAT]) begin
               st_nxt.shutCtrl[B_SHUT_STAT] = 1'b1;
            end else if (!causeRaw && !causeSync) begin
               st_nxt.shutCtrl[B_SHUT_STAT] = 1'b0;
            end
         end
         // a live cause always wins over any clear
         if (causeRaw || causeSync) begin
            st_nxt.shutCtrl[B_SHUT_STAT] = 1'b1;
         end
         if (statNow) begin
            st_nxt.heldShut = 1'b1;
         end else if (tmrLink.periodStart) begin
            st_nxt.heldShut = 1'b0;
         end
         if (tmrLink.periodStart) begin
            st_nxt.dutyLatched = {st_r.dutyHigh, st_r.modeCtrl[DLSB_HI:DLSB_LO]};
            st_nxt.irqFlags1[B_TMR_FLAG] = 1'b1;
         end
         st_nxt.pwmOn = tmrLink.run && ({tmrLink.count, tmrLink.fine} < st_r.dutyLatched);
         if (clkMonEnable && clkFailEvent) begin
            st_nxt.irqFlags2[B_CLK_FAIL] = 1'b1;
            st_nxt.oscRun = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
         st_r.bus <= BUS_IDLE;
         st_r.periodLimit <= RST_PERIOD;
         st_r.pinDir <= RST_DIR;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_begin_shut;
      tmrLink.periodStart && statNow;
   endsequence
   sequence s_released_mid;
      !statNow && st_r.heldShut && !tmrLink.periodStart && !sleepMode;
   endsequence

   a_auto_restart: assert property (
      (restartEn && statNow && !causeRaw && !causeSync && !shutWr && !sleepMode) |=> !statNow)
      else $error("status not cleared by auto restart");
   a_restart_gate: assert property (
      (!restartEn && statNow && !shutWr) |=> statNow)
      else $error("status cleared without restart enable");
   a_sw_clear: assert property (
      (shutWr && !st_r.wData[B_SHUT_STAT] && !causeRaw && !causeSync && !sleepMode) |=> !statNow)
      else $error("software clear lost");
   a_resume_edge: assert property (
      s_released_mid |=> st_r.heldShut && shutNow)
      else $error("outputs resumed mid period");
   a_write_locked: assert property (
      (shutWr && causeRaw) |=> statNow)
      else $error("status cleared while cause active");
   a_cmp_level: assert property (
      (srcSel == SRC_CMP1 && cmp1Out)[*2] |-> statNow)
      else $error("comparator level not holding status");
   a_sw_force: assert property (
      (shutWr && st_r.wData[B_SHUT_STAT] && !sleepMode) |=> statNow ##0 shutNow)
      else $error("forced shutdown missing");
   a_reset_pins: assert property (@(posedge clk) disable iff (1'b0)
      srst |=> bridgeOe == '0 && st_r.pinDir == RST_DIR)
      else $error("pins driving after reset");
   a_polarity: assert property (
      !shutNow |-> bridgeOut[0] == (st_r.pwmOn ^ st_r.modeCtrl[B_POL_AC]))
      else $error("a pin polarity wrong");
   a_period_flag: assert property (
      (tmrLink.periodStart && !sleepMode) |=> st_r.irqFlags1[B_TMR_FLAG])
      else $error("period flag not set");
   a_duty_load: assert property (
      (tmrLink.periodStart && !sleepMode) |=>
      st_r.dutyLatched == {$past(st_r.dutyHigh), $past(st_r.modeCtrl[DLSB_HI:DLSB_LO])})
      else $error("duty not latched at period start");
   a_sleep_hold: assert property (
      (sleepMode && !shutWr) |=> statNow == $past(statNow) && $stable(st_r.heldShut))
      else $error("state moved in sleep");
   a_clk_fail: assert property (
      (clkMonEnable && clkFailEvent && !sleepMode) |=> st_r.irqFlags2[B_CLK_FAIL] && internalOscRun)
      else $error("clock fail not flagged");
   a_async_force: assert property (
      (causeRaw && !st_r.shutCtrl[AC_HI]) |-> bridgeOut[2] == st_r.shutCtrl[AC_LO])
      else $error("pin not forced by cause");
   a_hold_period: assert property (
      s_begin_shut |=> st_r.heldShut)
      else $error("period not held in shutdown");
   a_sync_path: assert property (
      (srcSel == SRC_FLT && !faultInputN && !sleepMode)[*3] |-> causeSync)
      else $error("synchronised cause late");
endmodule

//--- core/pas_tmr_if.sv
// pas_tmr_if: link between the shutdown core and its period timer
`timescale 1ns/10ps
interface pas_tmr_if;
   logic [pas_pkg::TMR_W-1:0] periodLimit;
   logic [1:0] prescale;
   logic run;
   logic freeze;
   logic [pas_pkg::TMR_W-1:0] count;
   logic [1:0] fine;
   logic periodStart;
   modport timer (input periodLimit, prescale, run, freeze, output count, fine, periodStart);
   modport ctrl (output periodLimit, prescale, run, freeze, input count, fine, periodStart);
endinterface
